// ---- arac_pkg.sv ----
// Package for the converter reset, abort and channel-select control.
// Assumes one 10 MHz system clock and a synchronous active-high reset.
package arac_pkg;

    // ************************************************************
    // Widths and counts
    // ************************************************************
    localparam int ARAC_CH_N = 8;
    localparam int ARAC_CH_W = 3;
    localparam int ARAC_RES_W = 10;
    localparam int ARAC_PRS_W = 4;
    localparam int ARAC_DATA_W = 8;
    // Sample window in conversion clock cycles
    localparam int ARAC_SAMPLE_CYC = 14;
    localparam int ARAC_CNT_W = 5;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [ARAC_CH_W-1:0] ARAC_CH_RST = 3'h0;
    localparam logic [ARAC_PRS_W-1:0] ARAC_PRS_RST = 4'h0;
    localparam logic [ARAC_CH_N-1:0] ARAC_PE_RST = 8'h00;
    localparam logic [ARAC_RES_W-1:0] ARAC_SAR_RST = 10'h000;
    localparam logic [ARAC_RES_W-1:0] ARAC_SAR_MSB = 10'h200;
    localparam logic [ARAC_CNT_W-1:0] ARAC_CNT_RST = 5'h00;
    localparam logic [ARAC_PRS_W:0] ARAC_DIV_RST = 5'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ARAC_IDLE = 3'b001,
        ARAC_SAMPLE = 3'b010,
        ARAC_CONVERT = 3'b100
    } arac_state_e;

    // Control register contents
    typedef struct packed {
        logic power_up;
        logic [ARAC_PRS_W-1:0] prescale;
    } arac_ctrl_s;

    // Status-and-control register contents
    typedef struct packed {
        logic irq_en;
        logic [ARAC_CH_W-1:0] channel;
    } arac_sc_s;

endpackage : arac_pkg

// ---- arac_ctrl.sv ----
// Reset, abort and channel-select control of an eight-channel SAR converter.
// Assumes register strobes come from bus logic on clk_sys; the comparator
// output comes from the analog side and is synchronised here.
`timescale 1ns/100ps
module arac_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ctrl_wr,
    input wire arac_pkg::arac_ctrl_s ctrl_wdata,
    input wire logic sc_wr,
    input wire arac_pkg::arac_sc_s sc_wdata,
    input wire logic pe_wr,
    input wire logic [arac_pkg::ARAC_CH_N-1:0] pe_wdata,
    input wire logic res_hi_rd,
    input wire logic res_lo_rd,
    input wire logic cmp_in,
    output arac_pkg::arac_ctrl_s ctrl_q,
    output arac_pkg::arac_sc_s sc_q,
    output logic [arac_pkg::ARAC_CH_N-1:0] pe_q,
    output logic [arac_pkg::ARAC_CH_N-1:0] mux_sel,
    output logic [arac_pkg::ARAC_RES_W-1:0] sar_q,
    output logic [arac_pkg::ARAC_RES_W-1:0] result_q,
    output logic done_flag,
    output logic irq,
    output logic busy,
    output logic conv_clk_en
);
    import arac_pkg::*;

    arac_ctrl_s ctrl_reg;
    arac_sc_s sc_reg;
    logic [ARAC_CH_N-1:0] pe_reg;
    arac_state_e state_reg, state_next;
    logic [ARAC_RES_W-1:0] sar_reg, bit_reg, result_reg;
    logic [ARAC_CNT_W-1:0] cnt_reg;
    logic [ARAC_PRS_W:0] div_reg;
    logic done_reg, cmp_meta_reg, cmp_sync_reg;
    logic abort, tick;

    // ************************************************************
    // Registers
    // ************************************************************
    // Reset values loaded
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= '{power_up: 1'b0, prescale: ARAC_PRS_RST};
            sc_reg <= '{irq_en: 1'b0, channel: ARAC_CH_RST};
            pe_reg <= ARAC_PE_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl_reg <= ctrl_wdata;
            end
            if (sc_wr) begin
                sc_reg <= sc_wdata;
            end
            if (pe_wr) begin
                pe_reg <= pe_wdata;
            end
        end
    end

    // Comparator is asynchronous to clk_sys
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end else begin
            cmp_meta_reg <= cmp_in;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    // ************************************************************
    // Conversion clock
    // ************************************************************
    // Clock gated when down
    assign conv_clk_en = ctrl_reg.power_up;
    always_ff @(posedge clk_sys) begin
        if (rst || !ctrl_reg.power_up || sc_wr) begin
            div_reg <= ARAC_DIV_RST;
        end else if (tick) begin
            div_reg <= ARAC_DIV_RST;
        end else begin
            div_reg <= div_reg + 5'h01;
        end
    end
    // Factor (prescale+1)*2 bus cycles per tick
    // Limitation: prescale zero outruns the two-flop comparator path; use one or more
    assign tick = (div_reg == {ctrl_reg.prescale, 1'b1});

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Control write aborts
    assign abort = ctrl_wr || pe_wr || !ctrl_reg.power_up;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ARAC_IDLE: state_next = ARAC_IDLE;
            ARAC_SAMPLE: begin
                if (tick && cnt_reg == ARAC_CNT_W'(ARAC_SAMPLE_CYC - 1)) begin
                    state_next = ARAC_CONVERT;
                end
            end
            ARAC_CONVERT: begin
                if (tick && bit_reg[0]) begin
                    state_next = ARAC_IDLE;
                end
            end
            default: state_next = ARAC_IDLE;
        endcase
        if (sc_wr && ctrl_reg.power_up && !ctrl_wr && !pe_wr) begin
            state_next = ARAC_SAMPLE;
        end else if (abort) begin
            state_next = ARAC_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ARAC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state_next == ARAC_SAMPLE && state_reg != ARAC_SAMPLE || sc_wr) begin
            cnt_reg <= ARAC_CNT_RST;
        end else if (state_reg == ARAC_SAMPLE && tick) begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    // Comparator low drops the bit under trial
    wire [ARAC_RES_W-1:0] final_val = cmp_sync_reg ? sar_reg : (sar_reg & ~bit_reg);

    // SAR bits cleared
    // Trial bit stands in sar_reg, so the comparator sees the whole trial code
    always_ff @(posedge clk_sys) begin
        if (rst || abort || sc_wr) begin
            sar_reg <= ARAC_SAR_RST;
            bit_reg <= ARAC_SAR_MSB;
        end else if (state_reg == ARAC_SAMPLE && state_next == ARAC_CONVERT) begin
            sar_reg <= ARAC_SAR_MSB;
        end else if (state_reg == ARAC_CONVERT && tick) begin
            sar_reg <= final_val | (bit_reg >> 1);
            bit_reg <= bit_reg >> 1;
        end
    end

    wire finish = state_reg == ARAC_CONVERT && state_next == ARAC_IDLE && !abort;

    // Result kept across aborts; only a finished conversion updates it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_reg <= ARAC_SAR_RST;
        end else if (finish) begin
            result_reg <= final_val;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_reg <= 1'b0;
        end else if (finish) begin
            done_reg <= 1'b1;
        end else if (sc_wr || res_hi_rd || res_lo_rd) begin
            done_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // One-hot channel select
    genvar gi;
    generate
        for (gi = 0; gi < ARAC_CH_N; gi++) begin : g_mux
            assign mux_sel[gi] = (state_reg != ARAC_IDLE) && (sc_reg.channel == ARAC_CH_W'(gi));
        end
    endgenerate

    assign ctrl_q = ctrl_reg;
    assign sc_q = sc_reg;
    assign pe_q = pe_reg;
    assign sar_q = sar_reg;
    assign result_q = result_reg;
    assign done_flag = done_reg;
    assign irq = done_reg && sc_reg.irq_en;
    assign busy = state_reg != ARAC_IDLE;

    // ************************************************************
    // Checks
    // ************************************************************
    reset_idle_a: assert property (@(posedge clk_sys) rst |=> !busy && !done_flag && !irq)
        else $error("not idle after reset");
    reset_down_a: assert property (@(posedge clk_sys) rst |=> !ctrl_q.power_up)
        else $error("power-up set after reset");
    reset_sar_a: assert property (@(posedge clk_sys) rst |=> sar_q == ARAC_SAR_RST)
        else $error("sar not cleared");
    reset_cfg_a: assert property (@(posedge clk_sys) rst |=> pe_q == ARAC_PE_RST && !sc_q.irq_en)
        else $error("register not reset");
    ctrl_abort_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_wr |=> !busy)
        else $error("control write did not abort");
    pe_abort_a: assert property (@(posedge clk_sys) disable iff (rst)
        pe_wr && !sc_wr |=> !busy && pe_q == $past(pe_wdata))
        else $error("pin-enable write did not abort");
    down_abort_a: assert property (@(posedge clk_sys) disable iff (rst)
        !ctrl_q.power_up |=> !busy)
        else $error("converting while powered down");
    start_conv_a: assert property (@(posedge clk_sys) disable iff (rst)
        sc_wr && !ctrl_wr && !pe_wr && ctrl_q.power_up |=> busy && !done_flag)
        else $error("status write did not start");
    flag_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (res_hi_rd || res_lo_rd) && !finish |=> !done_flag)
        else $error("flag not cleared on read");
    idle_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        !busy && !sc_wr |=> !busy)
        else $error("started without status write");
    one_chan_a: assert property (@(posedge clk_sys) disable iff (rst)
        busy |-> $onehot(mux_sel))
        else $error("channel select not one-hot");
    keep_cfg_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(ctrl_q.power_up) && !$past(sc_wr) && !$past(pe_wr) |-> $stable(sc_q) && $stable(pe_q))
        else $error("power-up changed settings");
    irq_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(irq) |-> $past(finish))
        else $error("irq raised without a finished conversion");

    conv_done_c: cover property (@(posedge clk_sys) disable iff (rst) $rose(done_flag));
    restart_c: cover property (@(posedge clk_sys) disable iff (rst) busy && sc_wr);
    ctrl_abort_c: cover property (@(posedge clk_sys) disable iff (rst) busy && ctrl_wr);

endmodule : arac_ctrl

// ---- arac_cmp_model.sv ----
// Comparator model: eight analog channel levels seen through the input mux.
// Assumes mux_sel is one-hot while converting and sar_q holds the trial code,
// trial bit included, from one tick to the next.
`timescale 1ns/100ps
module arac_cmp_model (
    input wire logic clk_sys,
    input wire logic [7:0] mux_sel,
    input wire logic [9:0] sar_q,
    input wire logic [7:0][9:0] chan_level,
    output logic cmp_in
);
    logic [9:0] vin;
    logic tog = 1'b0;
    always_comb begin
        vin = 10'h000;
        for (int i = 0; i < 8; i++) begin
            if (mux_sel[i]) begin
                vin = vin | chan_level[i];
            end
        end
    end
    // Unselected: output toggles, so a stale level is never trusted
    always_ff @(posedge clk_sys) begin
        tog <= ~tog;
    end
    assign cmp_in = (mux_sel != 8'h00) ? (vin >= sar_q) : tog;
endmodule : arac_cmp_model

// ---- arac_ctrl_tb.sv ----
// Self-checking bench for the converter reset, abort and channel control.
// Assumes arac_pkg, arac_ctrl and arac_cmp_model are compiled first.
`timescale 1ns/100ps
module arac_ctrl_tb;
    import arac_pkg::*;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ctrl_wr = 1'b0;
    logic sc_wr = 1'b0;
    logic pe_wr = 1'b0;
    logic res_hi_rd = 1'b0;
    logic res_lo_rd = 1'b0;
    logic cmp_in;
    arac_ctrl_s ctrl_wdata = '0;
    arac_sc_s sc_wdata = '0;
    logic [7:0] pe_wdata = 8'h00;
    arac_ctrl_s ctrl_q;
    arac_sc_s sc_q;
    logic [7:0] pe_q, mux_sel;
    logic [9:0] sar_q, result_q, last;
    logic done_flag, irq, busy, conv_clk_en;
    // Boundary codes on some channels
    logic [7:0][9:0] level = {10'h3FF, 10'h2C4, 10'h1A3, 10'h200,
                              10'h1FF, 10'h0F0, 10'h001, 10'h000};
    int fails = 0;
    int comparisons = 0;
    always #50 clk_sys = ~clk_sys;
    arac_ctrl u_arac_ctrl (.clk_sys(clk_sys), .rst(rst), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .sc_wr(sc_wr), .sc_wdata(sc_wdata), .pe_wr(pe_wr),
        .pe_wdata(pe_wdata), .res_hi_rd(res_hi_rd), .res_lo_rd(res_lo_rd),
        .cmp_in(cmp_in), .ctrl_q(ctrl_q), .sc_q(sc_q), .pe_q(pe_q), .mux_sel(mux_sel),
        .sar_q(sar_q), .result_q(result_q), .done_flag(done_flag), .irq(irq),
        .busy(busy), .conv_clk_en(conv_clk_en));
    arac_cmp_model u_arac_cmp_model (.clk_sys(clk_sys), .mux_sel(mux_sel),
        .sar_q(sar_q), .chan_level(level), .cmp_in(cmp_in));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(posedge clk_sys);
        #1;
        s = 1'b1;
        @(posedge clk_sys);
        #1;
        s = 1'b0;
    endtask : pulse
    task automatic start(input logic [2:0] ch, input logic ie);
        sc_wdata = '{ie, ch};
        pulse(sc_wr);
        chk(busy, 1'b1, "start busy");
        chk(mux_sel, 8'h01 << ch, "one-hot channel");
        chk(done_flag, 1'b0, "done cleared by write");
    endtask : start
    task automatic finish(input logic [2:0] ch, input logic ie);
        int n;
        n = 0;
        while (done_flag !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        last = level[ch];
        chk({busy, done_flag, irq}, {2'b01, ie}, "finish flags");
        chk(result_q, last, "result code");
    endtask : finish
    // Watches every cycle, not just the end of the span
    task automatic idle_chk;
        int n;
        n = 0;
        repeat (120) begin
            @(posedge clk_sys);
            #1;
            n += (busy !== 1'b0);
        end
        chk(n, 0, "stays idle");
    endtask : idle_chk
    task automatic rst_chk;
        chk({ctrl_q, sc_q, pe_q, sar_q, done_flag, irq, busy, conv_clk_en}, '0,
            "reset state");
        chk({mux_sel, result_q}, '0, "reset outputs");
    endtask : rst_chk
    task automatic print_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // ************************************************************
    // Tests
    // ************************************************************
    // About 1700 cycles expected; roughly twelve times that before giving up
    initial begin
        #2000000;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        rst_chk();
        sc_wdata = '{1'b1, 3'h5};
        pulse(sc_wr);
        chk({busy, sc_q}, 5'h0D, "start while down");
        pe_wdata = 8'hA5;
        pulse(pe_wr);
        ctrl_wdata = '{1'b1, 4'h1};
        pulse(ctrl_wr);
        chk({conv_clk_en, sc_q, pe_q}, {1'b1, 4'hD, 8'hA5}, "power up keeps");
        idle_chk();
        for (int i = 0; i < 8; i++) begin
            start(i[2:0], i[0]);
            finish(i[2:0], i[0]);
            if (i[1]) begin
                pulse(res_hi_rd);
            end else begin
                pulse(res_lo_rd);
            end
            chk(done_flag, 1'b0, "read clears done");
        end
        start(3'h2, 1'b1);
        repeat (20) @(posedge clk_sys);
        #1;
        start(3'h6, 1'b0);
        finish(3'h6, 1'b0);
        // Abort by control write, pin-enable write, then power down
        for (int k = 0; k < 3; k++) begin
            start(3'h3, 1'b1);
            repeat (10) @(posedge clk_sys);
            #1;
            if (k == 1) begin
                pe_wdata = 8'h3C;
                pulse(pe_wr);
            end else begin
                ctrl_wdata = '{k == 0, 4'h1};
                pulse(ctrl_wr);
            end
            chk({busy, done_flag, result_q}, {2'b00, last}, "abort");
            idle_chk();
        end
        chk({conv_clk_en, pe_q}, {1'b0, 8'h3C}, "powered down");
        ctrl_wdata = '{1'b1, 4'h1};
        pulse(ctrl_wr);
        start(3'h7, 1'b1);
        finish(3'h7, 1'b1);
        pulse(rst);
        rst_chk();
        pulse(ctrl_wr);
        start(3'h4, 1'b0);
        repeat (30) @(posedge clk_sys);
        #1;
        pulse(rst);
        rst_chk();
        idle_chk();
        print_verdict();
    end
endmodule : arac_ctrl_tb
